// ===== rtl/arnf_pkg.sv
package arnf_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] FILT_SET_OFS = 12'h100; // Set alias
   localparam logic [11:0] FILT_CLR_OFS = 12'h104; // Clear alias
   localparam logic [11:0] BUSID_OFS = 12'h110; // Local bus identifier
   localparam logic [31:0] FILT_RST = 32'h0000_0000; // All sources refused
   localparam logic [9:0] BUSID_RST = 10'h3ff; // Local bus after reset
   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int ALL_BUS_BIT = 31; // Accept all remote buses
   localparam int NODE_BITS = 31; // Bits 30..0 serve nodes 62..32
   localparam logic [5:0] NODE_BASE = 6'h20; // Node number of bit 0
   localparam logic [5:0] NODE_TOP = 6'h3e; // Node number of bit 30
   localparam int BUSID_LSB = 6; // Bus field position in id word
   localparam int BUSID_W = 10; // Bus field width
endpackage

// ===== rtl/arnf_decide.sv
`timescale 1ns/1ps
`default_nettype none
// Combinational accept decision for one source node identifier
module arnf_decide (
   // Filter and local identity
   input wire logic [31:0] filt,
   input wire logic [9:0] local_bus,
   // Packet source
   input wire logic [15:0] src_id,
   // Decision
   output logic accept
);
   logic [9:0] src_bus; // Bus part of source id
   logic [5:0] src_node; // Node part of source id
   logic [5:0] idx; // Filter bit index
   assign src_bus = src_id[15:6];
   assign src_node = src_id[5:0];
   assign idx = src_node - arnf_pkg::NODE_BASE;
   // ------------------------------------------------------------
   // Decision
   // ------------------------------------------------------------
   always_comb begin
      if (src_bus != local_bus) begin
         // Remote bus only passes on the catch-all bit
         accept = filt[arnf_pkg::ALL_BUS_BIT];
      end else if (src_node >= arnf_pkg::NODE_BASE && src_node <= arnf_pkg::NODE_TOP) begin
         // Node n maps to bit n-32
         accept = filt[idx[4:0]];
      end else begin
         // Low nodes belong to the other half, broadcast never matches
         accept = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/arnf_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Check source of physical and request-context packets
// - Rejected packet gets no ack, no queue
// - Per-node check only for local bus sources
// - Remote buses pass only with bit 31
// - Bit 30 admits node 62
// - Bits 29..19 admit nodes 61..51
// - Set/clear aliases, both read filter value
// - Filter clears to zero on reset
// - Bits 18..0 admit nodes 50..32
// - Writable bus identifier defines local bus
module arnf_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Receive path: header presented with its strobe
   input wire logic pkt_valid,
   input wire logic pkt_to_filtered_ctx,
   input wire logic [15:0] pkt_src_id,
   // Receive decision, one cycle after the header
   output logic pkt_done,
   output logic pkt_ack,
   output logic pkt_queue,
   // Copy of the filter for the receive path, one cycle behind
   output logic [31:0] filter_value
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [31:0] filt_q; // Filter bits
   logic [9:0] bus_q; // Local bus identifier
   logic [31:0] rdata_q; // Read data
   logic done_q; // Decision strobe
   logic ack_q; // Acknowledge
   logic queue_q; // Queue into context
   logic accept; // Decision from the filter
   logic wr_set; // Write hits set alias
   logic wr_clr; // Write hits clear alias

   assign wr_set = reg_wr && reg_addr == arnf_pkg::FILT_SET_OFS;
   assign wr_clr = reg_wr && reg_addr == arnf_pkg::FILT_CLR_OFS;

   arnf_decide i_arnf_decide (
      .filt(filt_q),
      .local_bus(bus_q),
      .src_id(pkt_src_id),
      .accept(accept)
   );

   // ------------------------------------------------------------
   // Filter register
   // ------------------------------------------------------------
   // Set and clear never meet: one strobe per cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         filt_q <= arnf_pkg::FILT_RST;
      end else if (clk_en) begin
         if (wr_set) begin
            filt_q <= filt_q | reg_wdata;
         end else if (wr_clr) begin
            filt_q <= filt_q & ~reg_wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Local bus identifier
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bus_q <= arnf_pkg::BUSID_RST;
      end else if (clk_en && reg_wr && reg_addr == arnf_pkg::BUSID_OFS) begin
         bus_q <= reg_wdata[arnf_pkg::BUSID_LSB +: arnf_pkg::BUSID_W];
      end
   end

   // ------------------------------------------------------------
   // Read data, valid the cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         if (!reg_rd) begin
            rdata_q <= 32'h0000_0000;
         end else if (reg_addr == arnf_pkg::FILT_SET_OFS) begin
            rdata_q <= filt_q;
         end else if (reg_addr == arnf_pkg::FILT_CLR_OFS) begin
            rdata_q <= filt_q;
         end else if (reg_addr == arnf_pkg::BUSID_OFS) begin
            rdata_q <= {16'h0000, bus_q, 6'h00};
         end else begin
            // Unmapped reads return zero
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   // ------------------------------------------------------------
   // Receive decision
   // ------------------------------------------------------------
   // Packets for other contexts are not filtered here and pass
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         done_q <= 1'b0;
         ack_q <= 1'b0;
         queue_q <= 1'b0;
      end else if (clk_en) begin
         done_q <= pkt_valid;
         if (pkt_valid) begin
            ack_q <= !pkt_to_filtered_ctx || accept;
            queue_q <= !pkt_to_filtered_ctx || accept;
         end else begin
            ack_q <= 1'b0;
            queue_q <= 1'b0;
         end
      end
   end

   // Mirror of the filter for the receive path
   logic [31:0] fv_q;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fv_q <= arnf_pkg::FILT_RST;
      end else if (clk_en) begin
         fv_q <= filt_q;
      end
   end

   assign reg_rdata = rdata_q;
   assign pkt_done = done_q;
   assign pkt_ack = ack_q;
   assign pkt_queue = queue_q;
   assign filter_value = fv_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_reject;
      pkt_valid && clk_en && pkt_to_filtered_ctx && !accept;
   endsequence

   a_reject_no_ack: assert property (s_reject |=> !pkt_ack && !pkt_queue)
      else $error("rejected packet acknowledged");
   a_remote_gate: assert property (pkt_valid && clk_en && pkt_to_filtered_ctx &&
         pkt_src_id[15:6] != bus_q |=> pkt_ack == $past(filt_q[31]))
      else $error("remote bus gate wrong");
   a_node62_bit: assert property (pkt_valid && clk_en && pkt_to_filtered_ctx &&
         pkt_src_id == {bus_q, 6'h3e} |=> pkt_ack == $past(filt_q[30]))
      else $error("node 62 gate wrong");
   a_node51_bit: assert property (pkt_valid && clk_en && pkt_to_filtered_ctx &&
         pkt_src_id == {bus_q, 6'h33} |=> pkt_ack == $past(filt_q[19]))
      else $error("node 51 gate wrong");
   a_node32_bit: assert property (pkt_valid && clk_en && pkt_to_filtered_ctx &&
         pkt_src_id == {bus_q, 6'h20} |=> pkt_ack == $past(filt_q[0]))
      else $error("node 32 gate wrong");
   a_low_node_rej: assert property (pkt_valid && clk_en && pkt_to_filtered_ctx &&
         pkt_src_id[15:6] == bus_q && pkt_src_id[5] == 1'b0 |=> !pkt_ack)
      else $error("low node accepted");
   a_set_alias: assert property (wr_set && clk_en |=> (filt_q & $past(reg_wdata)) ==
         $past(reg_wdata))
      else $error("set alias failed");
   a_clr_alias: assert property (wr_clr && clk_en |=> (filt_q & $past(reg_wdata)) == 0)
      else $error("clear alias failed");
   a_read_alias: assert property (reg_rd && clk_en && reg_addr == arnf_pkg::FILT_CLR_OFS
         |=> reg_rdata == $past(filt_q))
      else $error("read alias wrong");
   a_reset_zero: assert property ($rose(rst_n) |-> filt_q == 0)
      else $error("filter not cleared");
   a_ack_queue_tie: assert property (pkt_ack == pkt_queue)
      else $error("ack and queue differ");

   // ------------------------------------------------------------
   // Receive-path and register-port checks
   // ------------------------------------------------------------
   // Header steps: taken with the enable high, answered one cycle on
   sequence s_header;
      pkt_valid && clk_en;
   endsequence

   sequence s_unfiltered;
      pkt_valid && clk_en && !pkt_to_filtered_ctx;
   endsequence

   // Every header gets exactly one decision strobe
   a_done_follows: assert property (s_header |=> pkt_done)
      else $error("decision strobe missing");
   a_done_idle: assert property (!pkt_valid && clk_en |=> !pkt_done)
      else $error("decision strobe without header");
   // Other contexts are outside this filter and always pass
   a_unfiltered_pass: assert property (s_unfiltered |=> pkt_ack && pkt_queue)
      else $error("unfiltered packet refused");
   // An answer never appears without its strobe
   a_ack_needs_done: assert property (pkt_ack |-> pkt_done)
      else $error("acknowledge without decision");
   // Set alias reads the same word as the clear alias
   a_read_set_alias: assert property (reg_rd && clk_en && reg_addr == arnf_pkg::FILT_SET_OFS
         |=> reg_rdata == $past(filt_q))
      else $error("set alias read wrong");
   // Read data stands only in the cycle after the strobe
   a_rdata_idle: assert property (!reg_rd && clk_en |=> reg_rdata == 32'h0000_0000)
      else $error("read data without strobe");
   // Bus identifier takes its field from the written word
   a_bus_write: assert property (reg_wr && clk_en && reg_addr == arnf_pkg::BUSID_OFS
         |=> bus_q == $past(reg_wdata[arnf_pkg::BUSID_LSB +: arnf_pkg::BUSID_W]))
      else $error("bus identifier not written");
   // Zeros at either alias leave the filter alone
   a_zero_keeps: assert property ((wr_set || wr_clr) && clk_en && reg_wdata == 32'h0000_0000
         |=> $stable(filt_q))
      else $error("zero write changed filter");
   // Receive-path copy trails the filter by one cycle
   a_mirror_lag: assert property (clk_en |=> filter_value == $past(filt_q))
      else $error("filter copy stale");
   // A low enable freezes every register; only reset may move them
   a_freeze_hold: assert property (!clk_en |=> $stable(filt_q) && $stable(bus_q) &&
         $stable(reg_rdata) && $stable(pkt_done) && $stable(pkt_ack))
      else $error("state moved while frozen");
endmodule
`default_nettype wire

// ===== sim/arnf_remote_node.sv
`timescale 1ns/1ps
`default_nettype none
// Remote node: one request header per call
module arnf_remote_node (
   // Clock
   input wire logic mclk,
   // Header toward the receive path
   output logic pkt_valid,
   output logic pkt_to_filtered_ctx,
   output logic [15:0] pkt_src_id
);
   // ------
   // Header
   // ------
   initial begin
      pkt_valid = 1'b0;
      pkt_to_filtered_ctx = 1'b0;
      pkt_src_id = 16'h0000;
   end
   // Lines are inverted once released, so stale ids never look valid
   task automatic send(input logic [9:0] bus, input logic [5:0] node, input logic ctx);
      @(posedge mclk);
      pkt_valid <= 1'b1;
      pkt_to_filtered_ctx <= ctx;
      pkt_src_id <= {bus, node};
      @(posedge mclk);
      pkt_valid <= 1'b0;
      pkt_to_filtered_ctx <= ~ctx;
      pkt_src_id <= ~{bus, node};
   endtask
endmodule
`default_nettype wire

// ===== sim/async_request_node_filter_high_bench.sv
`timescale 1ns/1ps
`default_nettype none
module async_request_node_filter_high_bench;
   // -----
   // Ports
   // -----
   logic mclk = 1'b0;
   logic rst_n, clk_en, reg_wr, reg_rd, pkt_valid, pkt_ctx, pkt_done, pkt_ack, pkt_queue;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, filter_value;
   logic [15:0] pkt_src_id;
   int compares = 0; // Checks made
   int bad_count = 0; // Mismatches
   always #25 mclk = ~mclk;
   arnf_top i_arnf_top (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pkt_valid(pkt_valid), .pkt_to_filtered_ctx(pkt_ctx), .pkt_src_id(pkt_src_id),
      .pkt_done(pkt_done), .pkt_ack(pkt_ack), .pkt_queue(pkt_queue),
      .filter_value(filter_value));
   arnf_remote_node i_arnf_remote_node (.mclk(mclk), .pkt_valid(pkt_valid),
      .pkt_to_filtered_ctx(pkt_ctx), .pkt_src_id(pkt_src_id));
   // -----
   // Tasks
   // -----
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // Data is looked at only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Both aliases and the receive-path copy
   task automatic chkf(input logic [31:0] e);
      logic [31:0] d;
      rd(arnf_pkg::FILT_SET_OFS, d);
      chk("set alias", d, e);
      rd(arnf_pkg::FILT_CLR_OFS, d);
      chk("clear alias", d, e);
      chk("filter_value", filter_value, e);
   endtask
   task automatic pkt(input logic [9:0] b, input logic [5:0] n, input logic c, input logic e);
      i_arnf_remote_node.send(b, n, c);
      #1;
      chk("pkt_done", {31'h0, pkt_done}, 32'h1);
      chk("pkt_ack", {31'h0, pkt_ack}, {31'h0, e});
      chk("pkt_queue", {31'h0, pkt_queue}, {31'h0, e});
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // --------
   // Sequence
   // --------
   initial begin
      logic [31:0] d;
      rst_n = 1'b0;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 32'h0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      chkf(32'h0);
      $display("test reset done");
      // Mixed pattern: node 62 on, nodes 51 and 32 off
      wr(arnf_pkg::FILT_SET_OFS, 32'h5555_5555);
      wr(arnf_pkg::FILT_CLR_OFS, 32'h0000_0001);
      chkf(32'h5555_5554);
      for (int n = 0; n < 31; n++) begin
         pkt(10'h3ff, 6'(32 + n), 1'b1, !n[0] && n != 0);
      end
      pkt(10'h3ff, 6'h20, 1'b0, 1'b1);
      pkt(10'h001, 6'h3e, 1'b1, 1'b0);
      $display("test node map done");
      // Unmapped places leave the filter alone
      wr(12'h108, 32'hffff_ffff);
      rd(12'h10c, d);
      chk("unmapped read", d, 32'h0);
      wr(arnf_pkg::FILT_SET_OFS, 32'h8000_0000);
      wr(arnf_pkg::FILT_CLR_OFS, 32'h0000_0000);
      chkf(32'hd555_5554);
      pkt(10'h001, 6'h3e, 1'b1, 1'b1);
      pkt(10'h3ff, 6'h20, 1'b1, 1'b0);
      // Move the local bus: old bus now counts as remote
      wr(arnf_pkg::BUSID_OFS, 32'h0000_0140);
      rd(arnf_pkg::BUSID_OFS, d);
      chk("bus id", d, 32'h0000_0140);
      pkt(10'h005, 6'h20, 1'b1, 1'b0);
      pkt(10'h3ff, 6'h20, 1'b1, 1'b1);
      wr(arnf_pkg::FILT_CLR_OFS, 32'hffff_ffff);
      chkf(32'h0);
      pkt(10'h3ff, 6'h20, 1'b1, 1'b0);
      $display("test remote buses done");
      // Low enable: neither a write nor a header may take effect
      @(posedge mclk) clk_en <= 1'b0;
      wr(arnf_pkg::FILT_SET_OFS, 32'hffff_ffff);
      i_arnf_remote_node.send(10'h005, 6'h20, 1'b0);
      #1;
      chk("frozen done", {31'h0, pkt_done}, 32'h0);
      @(posedge mclk) clk_en <= 1'b1;
      chkf(32'h0);
      $display("test clock enable done");
      // Reset in mid-run clears filter and returns bus identifier to 3ff
      wr(arnf_pkg::FILT_SET_OFS, 32'h0000_00ff);
      @(posedge mclk) rst_n <= 1'b0;
      @(posedge mclk) rst_n <= 1'b1;
      chkf(32'h0);
      rd(arnf_pkg::BUSID_OFS, d);
      chk("bus id reset", d, 32'h0000_ffc0);
      $display("test mid reset done");
      wrap_up();
   end
   // Hang guard
   initial begin
      #200000;
      bad_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
